//--- rtl/ls1rd_defs.svh
// Constants for the local space 1 range register and its address decoder
`ifndef LS1RD_DEFS_SVH
`define LS1RD_DEFS_SVH

// Reset value of the range register
`define LS1RD_RANGE_RST 32'h0FFF0000

// Field positions inside the range register
`define LS1RD_SPACE_IO_BIT 0
`define LS1RD_LOC_LSB 1
`define LS1RD_PREF_BIT 3
`define LS1RD_MEM_MASK_LSB 4
`define LS1RD_IO_MASK_LSB 2

// Location field codes
`define LS1RD_LOC_32 2'h0
`define LS1RD_LOC_1MB 2'h1
`define LS1RD_LOC_64 2'h2
`define LS1RD_LOC_RSV 2'h3

// Lowest address bit above the 1 MB boundary
`define LS1RD_1MB_LSB 20

`endif

//--- rtl/ls1rd_match.sv
// Address comparator for one decode window
`timescale 1ns/1ns
`include "ls1rd_defs.svh"
module ls1rd_match (
  // Window setup
  input wire ls1rd_pkg::ls1rd_range_t range,
  input wire logic [31:0] base,
  // Offered access
  input wire ls1rd_pkg::ls1rd_acc_t acc,
  // Result
  output logic hit
);

  logic [31:0] mask;
  logic type_ok;
  logic place_ok;

  // Mask, access type and placement checks
  always_comb
  begin
    mask = ls1rd_pkg::dec_mask(range);
    type_ok = (acc.is_io == range.space_io);
    place_ok = 1'b1;
    if (!range.space_io && range.loc == `LS1RD_LOC_1MB)
      place_ok = (acc.addr[31:`LS1RD_1MB_LSB] == 12'h000);
    hit = acc.valid && type_ok && place_ok && (((acc.addr ^ base) & mask) == 32'h00000000);
  end

endmodule // ls1rd_match

//--- rtl/ls1rd_pkg.sv
// Types and shared decode function for the local space 1 range decoder
package ls1rd_pkg;

  // Range register layout, bit 31 down to bit 0
  typedef struct packed {
    logic [27:0] mask_hi;
    logic prefetch;
    logic [1:0] loc;
    logic space_io;
  } ls1rd_range_t;

  // One host access offered for decode
  typedef struct packed {
    logic valid;
    logic is_io;
    logic [31:0] addr;
  } ls1rd_acc_t;

  // Register write port
  typedef struct packed {
    logic wr;
    logic [3:0] be;
    logic [31:0] wdata;
  } ls1rd_wr_t;

  // Whole state of the top module
  typedef struct packed {
    ls1rd_range_t range;
    logic claim;
    logic claim_bar0;
    logic [31:0] rd_data;
  } ls1rd_state_t;

  // Effective decode mask: I/O mapping pulls bits 3:2 into the mask
  function automatic logic [31:0] dec_mask(input ls1rd_range_t r);
    logic [31:0] raw;
    raw = r;
    if (r.space_io)
      dec_mask = {raw[31:2], 2'h0};
    else
      dec_mask = {raw[31:4], 4'h0};
  endfunction

endpackage

//--- rtl/ls1rd_top.sv
// Local space 1 range register with host address decode
`timescale 1ns/1ns
`include "ls1rd_defs.svh"
module ls1rd_top #(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register write port and read data
  input wire ls1rd_pkg::ls1rd_wr_t reg_wr,
  output logic [31:0] rd_data_q,
  // Decode setup from neighbouring registers
  input wire logic decode_en,
  input wire logic queue_status_control_0,
  input wire logic [31:0] host_base_address_3,
  input wire logic [31:0] host_base_address_0,
  // Host access and claim results
  input wire ls1rd_pkg::ls1rd_acc_t acc,
  output logic claim_q,
  output logic claim_bar0_q,
  // Mapping attributes for the rest of the bridge
  output logic space_io_q,
  output logic [1:0] loc_q,
  output logic prefetch_q
);

  // The decoder is written for a 32-bit host address
  if (ADDR_W != 32)
  begin : g_bad_width
    $error("ls1rd_top: ADDR_W must be 32");
  end

  ls1rd_pkg::ls1rd_state_t state_q;
  ls1rd_pkg::ls1rd_state_t state_d;
  logic [31:0] win_base;
  logic win_hit;
  logic [31:0] cur_raw;

  // Window base follows the mode: alternate mode sizes base address 0
  // alternate window select
  assign win_base = queue_status_control_0 ? host_base_address_0 : host_base_address_3;
  assign cur_raw = state_q.range;

  // Shared comparator for whichever window is active
  ls1rd_match u_match (
    .range(state_q.range),
    .base(win_base),
    .acc(acc),
    .hit(win_hit)
  );

  // Next state: register writes, claim pulses and readback copy
  always_comb
  begin
    logic [31:0] nxt;
    nxt = state_q.range;
    state_d = state_q;
    // Byte lanes update independently so software may touch a field alone
    if (reg_wr.wr)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (reg_wr.be[i])
          nxt[i*8 +: 8] = reg_wr.wdata[i*8 +: 8];
      end
    end
    state_d.range = nxt;
    state_d.claim = win_hit && decode_en && !queue_status_control_0;
    state_d.claim_bar0 = win_hit && queue_status_control_0;
    // Readback lags the stored value by one cycle to keep the output registered
    state_d.rd_data = cur_raw;
    if (rst)
    begin
      state_d.range = ls1rd_pkg::ls1rd_range_t'(`LS1RD_RANGE_RST);
      state_d.claim = 1'b0;
      state_d.claim_bar0 = 1'b0;
      state_d.rd_data = `LS1RD_RANGE_RST;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    state_q <= state_d;
  end

  // Outputs come straight from the state flops
  assign rd_data_q = state_q.rd_data;
  assign claim_q = state_q.claim;
  assign claim_bar0_q = state_q.claim_bar0;
  assign space_io_q = state_q.range.space_io;
  assign loc_q = state_q.range.loc;
  assign prefetch_q = state_q.range.prefetch;

  // Checks on the decode and the register behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [31:0] chk_mask;
  logic acc_match;
  assign chk_mask = ls1rd_pkg::dec_mask(state_q.range);
  assign acc_match = (((acc.addr ^ win_base) & chk_mask) == 32'h00000000);

  a_reset_default: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> cur_raw == `LS1RD_RANGE_RST)
    else $error("range not at default after reset");

  a_write_stores: assert property (reg_wr.wr && reg_wr.be == 4'hF
    |=> cur_raw == $past(reg_wr.wdata) ##1 rd_data_q == $past(reg_wr.wdata, 2))
    else $error("full write not stored or not read back");

  a_lane_hold: assert property (reg_wr.wr && reg_wr.be == 4'h1
    |=> cur_raw[31:8] == $past(cur_raw[31:8]))
    else $error("unselected byte lanes changed");

  a_claim_match: assert property (acc.valid && !acc.is_io && !state_q.range.space_io && decode_en
    && !queue_status_control_0 && state_q.range.loc != `LS1RD_LOC_1MB && acc_match
    |=> claim_q && !claim_bar0_q)
    else $error("matching memory access not claimed");

  a_claim_cause: assert property (claim_q |-> $past(acc.valid) && $past(acc_match)
    && $past(decode_en))
    else $error("claim without a masked match");

  a_alt_window: assert property (queue_status_control_0 |=> !claim_q)
    else $error("space 1 claimed in alternate mode");

  a_prefetch_ignored: assert property (acc.valid && !acc.is_io && !state_q.range.space_io && state_q.range.prefetch
    && decode_en && !queue_status_control_0 && state_q.range.loc != `LS1RD_LOC_1MB
    && ((acc.addr ^ win_base) & {cur_raw[31:4], 4'h0}) == 32'h00000000 |=> claim_q)
    else $error("prefetch bit changed memory decode");

  a_io_bit2: assert property (acc.valid && state_q.range.space_io && state_q.range.loc[1]
    && acc.addr[2] != win_base[2] |=> !claim_q && !claim_bar0_q)
    else $error("I/O decode ignored bit 2");

  a_below_1mb: assert property (acc.valid && !state_q.range.space_io
    && state_q.range.loc == `LS1RD_LOC_1MB && acc.addr[31:20] != 12'h000
    |=> !claim_q && !claim_bar0_q)
    else $error("access above 1 MB claimed");

  c_mem_claim: cover property (claim_q && !space_io_q);
  c_io_claim: cover property (claim_q && space_io_q);
  c_bar0_claim: cover property (claim_bar0_q);
  c_write_then_claim: cover property (reg_wr.wr ##1 acc.valid ##1 claim_q);

endmodule // ls1rd_top

//--- testbench/ls1rd_host.sv
// Host master model that offers one decode access per request
`timescale 1ns/1ns
module ls1rd_host (
  // Clock
  input wire logic clk,
  // Request from the bench
  input wire logic go,
  input wire logic go_io,
  input wire logic [31:0] go_addr,
  // Access offered to the decoder
  output ls1rd_pkg::ls1rd_acc_t acc
);
  initial acc = '0;
  // One-cycle offer; idle address is inverted so a stale value never matches by luck
  always @(posedge clk)
    acc <= go ? {1'b1, go_io, go_addr} : {1'b0, ~acc.is_io, ~acc.addr};
endmodule // ls1rd_host

//--- testbench/tb.sv
// Self-checking bench for the local space 1 range decoder
`timescale 1ns/1ns
module tb;
  logic clk = 0, rst = 1, den = 0, qsc = 0, go = 0, go_io = 0, c1, c0, sio, pf;
  logic [1:0] loc;
  logic [31:0] go_addr = 32'h0, b3 = 32'h0, b0 = 32'h0, rd, m = 32'h0FFF0000, w, msk, bs;
  ls1rd_pkg::ls1rd_wr_t reg_wr = '0;
  ls1rd_pkg::ls1rd_acc_t acc;
  int fail_count = 0, check_count = 0, seed = 32'h44CD, k;
  // Clock of 50 ns period
  always #25 clk = ~clk;
  ls1rd_host host (.clk(clk), .go(go), .go_io(go_io), .go_addr(go_addr), .acc(acc));
  ls1rd_top dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .rd_data_q(rd), .decode_en(den),
    .queue_status_control_0(qsc), .host_base_address_3(b3), .host_base_address_0(b0),
    .acc(acc), .claim_q(c1), .claim_bar0_q(c0), .space_io_q(sio), .loc_q(loc), .prefetch_q(pf));
  // Compare register readback or attribute fields against the bench model
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Compare the two claim pulses against the bench model
  task automatic cmp_claim(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Register write, then readback and attribute fields once settled
  task automatic wr(input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    reg_wr <= {1'b1, be, d};
    @(posedge clk);
    reg_wr.wr <= 1'b0;
    // Model keeps unselected byte lanes
    for (int i = 0; i < 4; i++)
      if (be[i])
        m[i*8 +: 8] = d[i*8 +: 8];
    repeat (2) @(posedge clk);
    #1;
    cmp_reg(rd, m);
    cmp_reg({28'h0, pf, loc, sio}, m & 32'hF);
  endtask
  // One access through the host model, claim sampled in its one-cycle slot
  task automatic probe(input logic [31:0] a, input logic io);
    logic ok;
    @(posedge clk);
    go <= 1'b1;
    go_addr <= a;
    go_io <= io;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    msk = m[0] ? {m[31:2], 2'h0} : {m[31:4], 4'h0};
    bs = qsc ? b0 : b3;
    ok = io == m[0] && ((a ^ bs) & msk) == 32'h0 && !(!m[0] && m[2:1] == 2'h1 && a[31:20] != 12'h0);
    cmp_claim({c1, c0}, {ok && den && !qsc, ok && qsc});
  endtask
  // Hang guard
  initial
  begin
    repeat (50000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    cmp_reg(rd, 32'h0FFF0000);
    cmp_reg({28'h0, pf, loc, sio}, 32'h0);
    for (int i = 0; i < 80; i++)
    begin
      k = 2 + {$random(seed)} % 30;
      w = (32'hFFFFFFFF << k) | ($random(seed) & 32'hF);
      // bit 1 kept low in I/O mapping
      if (w[0])
        w[1] = 1'b0;
      // Low lane alone: the upper lanes must keep the previous mask
      if (i % 7 == 3)
        wr({~w[31:8], m[7:4], w[3:0]}, 4'h1);
      wr(w, 4'hF);
      @(posedge clk);
      den <= i % 3 != 0;
      qsc <= i % 5 == 0;
      b3 <= i % 4 == 0 ? $random(seed) & 32'h000FFFFF : $random(seed);
      b0 <= $random(seed);
      for (int j = 0; j < 4; j++)
      begin
        @(posedge clk);
        // Mask of the window just written, so matching addresses really match
        msk = m[0] ? {m[31:2], 2'h0} : {m[31:4], 4'h0};
        bs = qsc ? b0 : b3;
        probe(j < 3 ? bs ^ ($random(seed) & ~msk) : $random(seed), j == 1 ? !m[0] : m[0]);
      end
    end
    finish_test();
  end
endmodule // tb
